// ==== pkg/trc_pkg.sv ====
/*
  Constants, encodings and register layout for the trinary remote code link.
  Assumes a single 40 MHz system clock and an APB register port.
*/
package trc_pkg;

  // ********************************************************************
  // System clock.
  // ********************************************************************
  localparam int CLK_HZ = 40000000;

  // ********************************************************************
  // Register offsets, fields and reset values.
  // ********************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_LOCAL_ADDR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ENC_CODE = 8'h0c;
  localparam logic [15:0] CTRL_RESET = 16'h0028;
  localparam logic [15:0] DIV_MIN = 16'h0004;
  localparam logic [17:0] LOCAL_ADDR_RESET = 18'h00000;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_AVALID_BIT = 2;
  localparam int ST_REQ_BIT = 3;
  localparam int ST_NIBBLE_LSB = 4;

  // ********************************************************************
  // Digit codes.
  // ********************************************************************
  localparam logic [1:0] DIG_ZERO = 2'h0;
  localparam logic [1:0] DIG_ONE = 2'h1;
  localparam logic [1:0] DIG_OPEN = 2'h2;
  localparam logic [1:0] DIG_BAD = 2'h3;
  localparam int DIGITS = 9;
  localparam int NIB_ADDR_DIGITS = 5;

  // ********************************************************************
  // Encoder timing in encoder clock periods.
  // ********************************************************************
  localparam logic [7:0] TICKS_PER_PULSE = 8'h04;
  localparam logic [1:0] SHORT_HIGH = 2'h1;
  localparam logic [1:0] LONG_HIGH = 2'h3;
  localparam logic [7:0] DATA_PERIOD_TICKS = 8'h08;
  localparam logic [7:0] WORD_TICKS = 8'(DIGITS * 8);
  localparam logic [7:0] GAP_TICKS = 8'(3 * 8);

  // ********************************************************************
  // Decoder thresholds as fractions of one encoder clock period.
  // ********************************************************************
  localparam logic [9:0] WIDE_NUM = 10'd172;
  localparam logic [9:0] WIDE_DEN = 10'd100;
  localparam logic [9:0] EOT_NUM = 10'd335;
  localparam logic [9:0] EOW_NUM = 10'd134;
  localparam logic [9:0] TENTHS_DEN = 10'd10;

  // ********************************************************************
  // Encoder states.
  // ********************************************************************
  typedef enum logic [2:0] {
    ENC_IDLE = 3'b001,
    ENC_SEND = 3'b010,
    ENC_GAP = 3'b100
  } trc_enc_state_type;

endpackage

// ==== core/trc_link.sv ====
/*
  Trinary remote code link: serial encoder for nine three-state pins and two
  decoders (five-digit address with data nibble, nine-digit address only).
  Assumes all inputs are synchronous to clk and that the pin wires resolve the
  weak drive from the output enables outside this module.
*/
`timescale 1ns/10ps

module trc_link (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder transmit request and serial output.
  input wire logic send_request_n,
  input wire logic send_request_driven,
  output logic enc_dout,
  // Encoder three-state address and data pins.
  input wire logic [8:0] addr_data_in,
  output logic [8:0] addr_data_out,
  output logic [8:0] addr_data_oe_n,
  // Decoder serial input and results.
  input wire logic dec_din,
  output logic [3:0] decoded_nibble_outputs,
  output logic valid_rx_flag,
  output logic addr_valid_rx_flag
);

  // ********************************************************************
  // Helper functions.
  // ********************************************************************
  function automatic logic at_least(input logic [23:0] cnt, input logic [15:0] div,
                                    input logic [9:0] num, input logic [9:0] den);
    logic [39:0] lhs;
    logic [39:0] rhs;
    lhs = 40'(cnt) * 40'(den);
    rhs = 40'(div) * 40'(num);
    at_least = lhs >= rhs;
  endfunction

  function automatic logic digits_match(input logic [17:0] rx, input logic [17:0] loc,
                                        input logic [8:0] care);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < trc_pkg::DIGITS; i++)
    begin
      if (care[i] && (rx[2*i +: 2] != loc[2*i +: 2] || rx[2*i +: 2] == trc_pkg::DIG_BAD))
      begin
        ok = 1'b0;
      end
    end
    digits_match = ok;
  endfunction

  // ********************************************************************
  // Register file.
  // ********************************************************************
  logic [15:0] ctrl_div_r;
  logic [17:0] local_addr_r;
  logic [17:0] enc_code_r;
  logic [15:0] div_eff;
  logic req_low;
  logic [31:0] rdata_nxt;
  logic addr_ok;
  trc_pkg::trc_enc_state_type enc_state_r;

  assign div_eff = (ctrl_div_r < trc_pkg::DIV_MIN) ? trc_pkg::DIV_MIN : ctrl_div_r;
  assign req_low = send_request_driven ? !send_request_n : 1'b0;

  always_comb
  begin
    rdata_nxt = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
      trc_pkg::OFS_CTRL: rdata_nxt = {16'h0000, ctrl_div_r};
      trc_pkg::OFS_LOCAL_ADDR: rdata_nxt = {14'h0000, local_addr_r};
      trc_pkg::OFS_STATUS:
      begin
        rdata_nxt[trc_pkg::ST_BUSY_BIT] = enc_state_r != trc_pkg::ENC_IDLE;
        rdata_nxt[trc_pkg::ST_VALID_BIT] = valid_rx_flag;
        rdata_nxt[trc_pkg::ST_AVALID_BIT] = addr_valid_rx_flag;
        rdata_nxt[trc_pkg::ST_REQ_BIT] = req_low;
        rdata_nxt[trc_pkg::ST_NIBBLE_LSB +: 4] = decoded_nibble_outputs;
      end
      trc_pkg::OFS_ENC_CODE: rdata_nxt = {14'h0000, enc_code_r};
      default: addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_div_r <= trc_pkg::CTRL_RESET;
      local_addr_r <= trc_pkg::LOCAL_ADDR_RESET;
    end
    else if (psel && penable && pready && pwrite)
    begin
      if (paddr == trc_pkg::OFS_CTRL)
      begin
        ctrl_div_r <= pwdata[15:0];
      end
      if (paddr == trc_pkg::OFS_LOCAL_ADDR)
      begin
        local_addr_r <= pwdata[17:0];
      end
    end
  end

  // ********************************************************************
  // Encoder clock and sequencer.
  // ********************************************************************
  logic [15:0] div_cnt_r;
  logic [7:0] tick_cnt_r;
  logic first_r;
  logic pair_r;
  logic tick;
  logic sensing;
  logic [3:0] sense_idx;
  logic hi_phase;
  logic hi_seen_r;

  assign tick = div_cnt_r == div_eff - 16'h0001;
  assign sensing = enc_state_r == trc_pkg::ENC_GAP && tick_cnt_r < 8'(trc_pkg::DIGITS);
  assign sense_idx = tick_cnt_r[3:0];
  assign hi_phase = div_cnt_r < {1'b0, div_eff[15:1]};

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt_r <= 16'h0000;
    end
    else if (enc_state_r == trc_pkg::ENC_IDLE || tick)
    begin
      div_cnt_r <= 16'h0000;
    end
    else
    begin
      div_cnt_r <= div_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enc_state_r <= trc_pkg::ENC_IDLE;
      tick_cnt_r <= 8'h00;
      first_r <= 1'b0;
      pair_r <= 1'b0;
    end
    else
    begin
      case (enc_state_r)
        trc_pkg::ENC_IDLE:
        begin
          tick_cnt_r <= 8'h00;
          pair_r <= 1'b0;
          if (req_low)
          begin
            enc_state_r <= trc_pkg::ENC_GAP;
            first_r <= 1'b1;
          end
        end
        trc_pkg::ENC_GAP:
        begin
          if (tick)
          begin
            if (tick_cnt_r == trc_pkg::GAP_TICKS - 8'h01)
            begin
              tick_cnt_r <= 8'h00;
              first_r <= 1'b0;
              if (!first_r && !pair_r && !req_low)
              begin
                enc_state_r <= trc_pkg::ENC_IDLE;
              end
              else
              begin
                enc_state_r <= trc_pkg::ENC_SEND;
              end
            end
            else
            begin
              tick_cnt_r <= tick_cnt_r + 8'h01;
            end
          end
        end
        trc_pkg::ENC_SEND:
        begin
          if (tick)
          begin
            if (tick_cnt_r == trc_pkg::WORD_TICKS - 8'h01)
            begin
              tick_cnt_r <= 8'h00;
              pair_r <= !pair_r;
              enc_state_r <= trc_pkg::ENC_GAP;
            end
            else
            begin
              tick_cnt_r <= tick_cnt_r + 8'h01;
            end
          end
        end
        default:
        begin
          enc_state_r <= trc_pkg::ENC_IDLE;
          tick_cnt_r <= 8'h00;
        end
      endcase
    end
  end

  // ********************************************************************
  // Encoder pin sensing.
  // ********************************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_data_out <= 9'h000;
      addr_data_oe_n <= 9'h1ff;
      hi_seen_r <= 1'b0;
      enc_code_r <= 18'h00000;
    end
    else
    begin
      addr_data_out <= 9'h000;
      addr_data_oe_n <= 9'h1ff;
      if (sensing)
      begin
        addr_data_out[sense_idx] <= hi_phase;
        addr_data_oe_n[sense_idx] <= 1'b0;
        if (div_cnt_r == {1'b0, div_eff[15:1]})
        begin
          hi_seen_r <= addr_data_in[sense_idx];
        end
        if (tick)
        begin
          if (hi_seen_r && addr_data_in[sense_idx])
          begin
            enc_code_r[2*sense_idx +: 2] <= trc_pkg::DIG_ONE;
          end
          else if (!hi_seen_r && !addr_data_in[sense_idx])
          begin
            enc_code_r[2*sense_idx +: 2] <= trc_pkg::DIG_ZERO;
          end
          else
          begin
            enc_code_r[2*sense_idx +: 2] <= trc_pkg::DIG_OPEN;
          end
        end
      end
    end
  end

  // ********************************************************************
  // Encoder pulse shaping.
  // ********************************************************************
  logic [1:0] tx_digit;
  logic tx_long;
  logic [1:0] tx_width;

  assign tx_digit = enc_code_r[2*tick_cnt_r[6:3] +: 2];
  assign tx_width = tx_long ? trc_pkg::LONG_HIGH : trc_pkg::SHORT_HIGH;

  always_comb
  begin
    case (tx_digit)
      trc_pkg::DIG_ONE: tx_long = 1'b1;
      trc_pkg::DIG_OPEN: tx_long = !tick_cnt_r[2];
      default: tx_long = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enc_dout <= 1'b0;
    end
    else
    begin
      enc_dout <= enc_state_r == trc_pkg::ENC_SEND && tick_cnt_r[1:0] < tx_width;
    end
  end

  // ********************************************************************
  // Decoder pulse timing.
  // ********************************************************************
  logic din_q_r;
  logic [23:0] high_cnt_r;
  logic [23:0] low_cnt_r;
  logic eow_done_r;
  logic eot_done_r;
  logic eow_hit;
  logic eot_hit;
  logic din_fall;
  logic wide;

  assign din_fall = !dec_din && din_q_r;
  assign wide = at_least(high_cnt_r, div_eff, trc_pkg::WIDE_NUM, trc_pkg::WIDE_DEN);
  assign eow_hit = !dec_din && !eow_done_r &&
                   at_least(low_cnt_r, div_eff, trc_pkg::EOW_NUM, trc_pkg::TENTHS_DEN);
  assign eot_hit = !dec_din && !eot_done_r &&
                   at_least(low_cnt_r, div_eff, trc_pkg::EOT_NUM, trc_pkg::TENTHS_DEN);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      din_q_r <= 1'b0;
      high_cnt_r <= 24'h000000;
      low_cnt_r <= 24'h000000;
      eow_done_r <= 1'b0;
      eot_done_r <= 1'b0;
    end
    else
    begin
      din_q_r <= dec_din;
      if (dec_din)
      begin
        high_cnt_r <= din_q_r ? high_cnt_r + 24'h000001 : 24'h000001;
        low_cnt_r <= 24'h000000;
        eow_done_r <= 1'b0;
        eot_done_r <= 1'b0;
      end
      else
      begin
        if (low_cnt_r != 24'hffffff)
        begin
          low_cnt_r <= low_cnt_r + 24'h000001;
        end
        if (eow_hit)
        begin
          eow_done_r <= 1'b1;
        end
        if (eot_hit)
        begin
          eot_done_r <= 1'b1;
        end
      end
    end
  end

  // ********************************************************************
  // Decoder word assembly.
  // ********************************************************************
  logic [4:0] pulse_cnt_r;
  logic first_wide_r;
  logic [17:0] rx_word_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pulse_cnt_r <= 5'h00;
      first_wide_r <= 1'b0;
      rx_word_r <= 18'h00000;
    end
    else if (eow_hit)
    begin
      pulse_cnt_r <= 5'h00;
    end
    else if (din_fall && pulse_cnt_r <= 5'(2 * trc_pkg::DIGITS))
    begin
      pulse_cnt_r <= pulse_cnt_r + 5'h01;
      if (!pulse_cnt_r[0])
      begin
        first_wide_r <= wide;
      end
      else if (pulse_cnt_r < 5'(2 * trc_pkg::DIGITS))
      begin
        rx_word_r[2*pulse_cnt_r[4:1] +: 2] <= {first_wide_r ^ wide, wide};
      end
    end
  end

  // ********************************************************************
  // Decoder word checks.
  // ********************************************************************
  logic word_full;
  logic nib_match;
  logic addr_match;
  logic [3:0] rx_nibble;
  logic [3:0] stored_nibble_r;
  logic have_first_r;
  logic have_first9_r;

  assign word_full = pulse_cnt_r == 5'(2 * trc_pkg::DIGITS);
  assign nib_match = word_full && digits_match(rx_word_r, local_addr_r, 9'h01f) &&
                     digits_match(rx_word_r, rx_word_r, 9'h1e0);
  assign addr_match = word_full && digits_match(rx_word_r, local_addr_r, 9'h1ff);

  always_comb
  begin
    rx_nibble = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      rx_nibble[i] = rx_word_r[2*(trc_pkg::NIB_ADDR_DIGITS + i) +: 2] != trc_pkg::DIG_ZERO;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      valid_rx_flag <= 1'b0;
      decoded_nibble_outputs <= 4'h0;
      stored_nibble_r <= 4'h0;
      have_first_r <= 1'b0;
    end
    else if (eot_hit)
    begin
      valid_rx_flag <= 1'b0;
      have_first_r <= 1'b0;
    end
    else if (eow_hit)
    begin
      if (nib_match)
      begin
        stored_nibble_r <= rx_nibble;
        have_first_r <= 1'b1;
        if (have_first_r && rx_nibble == stored_nibble_r)
        begin
          decoded_nibble_outputs <= rx_nibble;
          valid_rx_flag <= 1'b1;
        end
        else if (have_first_r)
        begin
          valid_rx_flag <= 1'b0;
        end
      end
      else
      begin
        valid_rx_flag <= 1'b0;
        have_first_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      addr_valid_rx_flag <= 1'b0;
      have_first9_r <= 1'b0;
    end
    else if (eot_hit)
    begin
      addr_valid_rx_flag <= 1'b0;
      have_first9_r <= 1'b0;
    end
    else if (eow_hit)
    begin
      have_first9_r <= addr_match;
      addr_valid_rx_flag <= addr_match && have_first9_r;
    end
  end

endmodule

// ==== sim/trc_link_asserts.sv ====
/*
  Port checker for trc_link, attached by bind at the foot of this file.
  Assumes one clock domain and an active-low asynchronous reset.
*/
`timescale 1ns/10ps
module trc_link_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Encoder.
  input wire logic enc_dout,
  input wire logic [8:0] addr_data_out,
  input wire logic [8:0] addr_data_oe_n,
  // Decoders.
  input wire logic dec_din,
  input wire logic [3:0] decoded_nibble_outputs,
  input wire logic valid_rx_flag,
  input wire logic addr_valid_rx_flag
);
  localparam int MIN_QUIET = 40;
  logic [15:0] low_cnt_r;
  wire logic [8:0] drv_hi = addr_data_out & ~addr_data_oe_n;
  wire logic mapped = paddr inside {trc_pkg::OFS_CTRL, trc_pkg::OFS_LOCAL_ADDR,
    trc_pkg::OFS_STATUS, trc_pkg::OFS_ENC_CODE};

  // ********************************************************************
  // Quiet-time counter.
  // ********************************************************************
  // Counts cycles with the decoder input low.
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      low_cnt_r <= 16'h0000;
    else if (dec_din)
      low_cnt_r <= 16'h0000;
    else if (low_cnt_r != 16'hffff)
      low_cnt_r <= low_cnt_r + 16'h0001;

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_answer;
    pready ##1 !pready;
  endsequence

  chk_apb_ready: assert property (apb_setup |=> apb_answer)
    else $error("pready not one cycle after setup");
  chk_apb_err: assert property (apb_setup |=> (pslverr == !$past(mapped)) &&
    (!pslverr || prdata == 32'h00000000))
    else $error("pslverr or read data wrong for address");
  chk_reset_clear: assert property ($rose(rstn) |-> !valid_rx_flag &&
    !addr_valid_rx_flag && decoded_nibble_outputs == 4'h0 && addr_data_oe_n == 9'h1ff)
    else $error("outputs not cleared by reset");
  chk_one_pin: assert property ($countones(~addr_data_oe_n) <= 1)
    else $error("more than one pin driven");
  chk_drive_high: assert property (($changed(addr_data_oe_n) &&
    addr_data_oe_n != 9'h1ff) |-> drv_hi == ~addr_data_oe_n)
    else $error("pin not driven high first");
  chk_drive_low: assert property (($changed(addr_data_oe_n) &&
    $past(addr_data_oe_n) != 9'h1ff) |-> $past(drv_hi) == 9'h000)
    else $error("pin not driven low last");
  chk_dout_rest: assert property (enc_dout |-> addr_data_oe_n == 9'h1ff)
    else $error("serial output high while sensing");
  chk_valid_rise: assert property (($rose(valid_rx_flag) ||
    $rose(addr_valid_rx_flag)) |-> low_cnt_r >= MIN_QUIET)
    else $error("valid rose inside a word");
  chk_valid_fall: assert property (($fell(valid_rx_flag) ||
    $fell(addr_valid_rx_flag)) |-> low_cnt_r >= MIN_QUIET)
    else $error("valid fell inside a word");
  chk_nibble_hold: assert property ($changed(decoded_nibble_outputs) |-> valid_rx_flag)
    else $error("nibble changed without valid");
endmodule

bind trc_link trc_link_asserts i_trc_link_asserts (
  .clk, .rstn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .enc_dout, .addr_data_out, .addr_data_oe_n, .dec_din,
  .decoded_nibble_outputs, .valid_rx_flag, .addr_valid_rx_flag
);

// ==== sim/trc_tx_model.sv ====
/*
  Far-side sender model: drives the decoder input with coded words.
  Assumes the caller enters its task just after a rising clock edge.
*/
`timescale 1ns/10ps
module trc_tx_model #(
  parameter int T = 8
) (
  // Clock.
  input wire logic clk,
  // Serial line.
  output logic line
);
  initial line = 1'b0;

  // ********************************************************************
  // Pulses and words.
  // ********************************************************************
  task automatic pulse(input logic wide);
    line <= 1'b1;
    repeat (wide ? 3 * T : T) @(posedge clk);
    line <= 1'b0;
    repeat (wide ? T : 3 * T) @(posedge clk);
  endtask

  // Sends nine digits, digit 0 first; code 11 goes out as a narrow then a wide pulse.
  task automatic send_word(input logic [17:0] code);
    for (int d = 0; d < 9; d++)
    begin
      pulse(code[2 * d + 1] ^ code[2 * d]);
      pulse(code[2 * d]);
    end
  endtask
endmodule

// ==== sim/trc_link_tb.sv ====
/*
  Self-checking bench for trc_link: registers, encoder stream, decoders.
  Assumes the sender model drives the decoder input.
*/
`timescale 1ns/10ps
module trc_link_tb;
  localparam int T = 8;
  localparam logic [17:0] WD = 18'h12449;
  localparam logic [17:0] W2 = WD | 18'h04000;
  localparam logic [17:0] WA = WD ^ 18'h00003;
  localparam logic [17:0] WB = WD | 18'h00c00;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic send_request_n = 1'b1;
  logic send_request_driven = 1'b1;
  logic enc_dout;
  logic [8:0] addr_data_in;
  logic [8:0] addr_data_out;
  logic [8:0] addr_data_oe_n;
  logic dec_din;
  logic [3:0] decoded_nibble_outputs;
  logic valid_rx_flag;
  logic addr_valid_rx_flag;
  int n_fail = 0;
  int checks_done = 0;

  always #12.5 clk = ~clk;

  // Pins are tied low, tied high or open; an open pin follows the weak drive.
  always_comb
    for (int i = 0; i < 9; i++)
      addr_data_in[i] = WD[2 * i + 1] ? (addr_data_out[i] ^ addr_data_oe_n[i]) : WD[2 * i];

  trc_link i_trc_link (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .send_request_n, .send_request_driven, .enc_dout, .addr_data_in,
    .addr_data_out, .addr_data_oe_n, .dec_din, .decoded_nibble_outputs,
    .valid_rx_flag, .addr_valid_rx_flag
  );
  trc_tx_model #(.T(T)) i_trc_tx_model (.clk, .line(dec_din));

  // ********************************************************************
  // Checks and bus tasks.
  // ********************************************************************
  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %b got %b", name, exp, got);
    end
  endtask

  task automatic fail_stop();
    cmp_bit("wait done", 1'b1, 1'b0);
    report_and_stop();
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 50)
      fail_stop();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    cmp_bit("write err", exp_err, e);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    cmp_word(name, exp, r);
    cmp_bit("read err", exp_err, e);
  endtask

  // ********************************************************************
  // Stream tasks.
  // ********************************************************************
  task automatic measure(output int hi, output int lo, input int max_lo);
    int i;
    for (i = 0; i < 4000 && enc_dout !== 1'b1; i++)
      @(posedge clk);
    if (i == 4000)
      fail_stop();
    hi = 0;
    lo = 0;
    while (enc_dout === 1'b1 && hi < 4000)
    begin
      @(posedge clk);
      hi++;
    end
    while (enc_dout !== 1'b1 && lo < max_lo)
    begin
      @(posedge clk);
      lo++;
    end
  endtask

  task automatic get_word(output logic [17:0] code, output int gap);
    int h1, l1, h2, l2;
    for (int d = 0; d < 9; d++)
    begin
      measure(h1, l1, 400);
      measure(h2, l2, 400);
      code[2 * d +: 2] = (h1 > 2 * T) ? ((h2 > 2 * T) ? 2'h1 : 2'h2) : ((h2 > 2 * T) ? 2'h3 : 2'h0);
      cmp_word("pulse period", 4 * T, h1 + l1);
    end
    gap = h2 + l2;
  endtask

  task automatic run_words(input int n, input logic hold);
    logic [17:0] c;
    int g;
    for (int k = 0; k < n; k++)
    begin
      get_word(c, g);
      cmp_word("word code", {14'h0000, WD}, {14'h0000, c});
      if (hold && k == 2)
        send_request_n <= 1'b1;
      if (k < n - 1)
        cmp_word("word gap", 28 * T, g);
      else
        cmp_bit("stopped", 1'b1, g >= 400);
    end
  endtask

  task automatic flags(input logic v, input logic av, input logic [3:0] nib);
    cmp_bit("valid", v, valid_rx_flag);
    cmp_bit("addr valid", av, addr_valid_rx_flag);
    cmp_word("nibble", {28'h0000000, nib}, {28'h0000000, decoded_nibble_outputs});
  endtask

  // ********************************************************************
  // Main sequence.
  // ********************************************************************
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    flags(1'b0, 1'b0, 4'h0);
    cmp_word("oe_n", 32'h000001ff, {23'h000000, addr_data_oe_n});
    rd_chk("ctrl", trc_pkg::OFS_CTRL, {16'h0000, trc_pkg::CTRL_RESET}, 1'b0);
    rd_chk("local", trc_pkg::OFS_LOCAL_ADDR, 32'h00000000, 1'b0);
    wr(trc_pkg::OFS_CTRL, T, 1'b0);
    rd_chk("ctrl", trc_pkg::OFS_CTRL, T, 1'b0);
    wr(trc_pkg::OFS_LOCAL_ADDR, {14'h0000, WD}, 1'b0);
    rd_chk("local", trc_pkg::OFS_LOCAL_ADDR, {14'h0000, WD}, 1'b0);
    wr(8'h10, 32'hffffffff, 1'b1);
    rd_chk("unmapped", 8'h10, 32'h00000000, 1'b1);
    wr(trc_pkg::OFS_STATUS, 32'hffffffff, 1'b0);
    rd_chk("status", trc_pkg::OFS_STATUS, 32'h00000000, 1'b0);
    @(posedge clk);
    send_request_n <= 1'b0;
    @(posedge clk);
    send_request_n <= 1'b1;
    run_words(2, 1'b0);
    rd_chk("enc code", trc_pkg::OFS_ENC_CODE, {14'h0000, WD}, 1'b0);
    rd_chk("status", trc_pkg::OFS_STATUS, 32'h00000000, 1'b0);
    send_request_driven <= 1'b0;
    send_request_n <= 1'b0;
    repeat (300) @(posedge clk);
    rd_chk("status", trc_pkg::OFS_STATUS, 32'h00000000, 1'b0);
    send_request_driven <= 1'b1;
    run_words(4, 1'b1);
    rd_chk("status", trc_pkg::OFS_STATUS, 32'h00000000, 1'b0);
    i_trc_tx_model.send_word(WD);
    repeat (24 * T) @(posedge clk);
    flags(1'b0, 1'b0, 4'h0);
    i_trc_tx_model.send_word(WD);
    repeat (90) @(posedge clk);
    flags(1'b0, 1'b0, 4'h0);
    repeat (40) @(posedge clk);
    flags(1'b1, 1'b1, 4'hb);
    i_trc_tx_model.send_word(W2);
    repeat (130) @(posedge clk);
    flags(1'b0, 1'b0, 4'hb);
    i_trc_tx_model.send_word(W2);
    repeat (130) @(posedge clk);
    flags(1'b1, 1'b0, 4'hf);
    repeat (100) @(posedge clk);
    flags(1'b1, 1'b0, 4'hf);
    repeat (40) @(posedge clk);
    flags(1'b0, 1'b0, 4'hf);
    i_trc_tx_model.send_word(WA);
    repeat (24 * T) @(posedge clk);
    i_trc_tx_model.send_word(WA);
    repeat (130) @(posedge clk);
    flags(1'b0, 1'b0, 4'hf);
    i_trc_tx_model.send_word(WD);
    repeat (24 * T) @(posedge clk);
    i_trc_tx_model.send_word(WB);
    repeat (130) @(posedge clk);
    flags(1'b0, 1'b0, 4'hf);
    report_and_stop();
  end
endmodule
